// File: common/hcb_pkg.sv
// package: constants and types for the hardware configuration byte block
package hcb_pkg;
  // special-function addresses of the index/value pair
  localparam logic [7:0] SFR_CFG_INDEX = 8'h93;
  localparam logic [7:0] SFR_CFG_VALUE = 8'h94;
  // configuration byte indices
  localparam logic [5:0] IDX_SYSTEM    = 6'h3f;
  localparam logic [5:0] IDX_BROWNOUT  = 6'h3e;
  localparam logic [5:0] IDX_CLOCK     = 6'h3d;
  localparam int unsigned NUM_CFG_BYTES = 64;
  // erased values of the three decoded bytes and of the other bytes
  localparam logic [7:0] RST_SYSTEM    = 8'hff;
  localparam logic [7:0] RST_BROWNOUT  = 8'hff;
  localparam logic [7:0] RST_CLOCK     = 8'h07;
  localparam logic [7:0] RST_OTHER     = 8'hff;
  // fixed bit patterns and keep masks
  localparam logic [7:0] MASK_SYSTEM   = 8'hfb;
  localparam logic [7:0] FIX_SYSTEM    = 8'h04;
  localparam logic [7:0] MASK_BROWNOUT = 8'h04;
  localparam logic [7:0] FIX_BROWNOUT  = 8'hfb;
  localparam logic [7:0] MASK_CLOCK    = 8'h07;
  localparam logic [7:0] FIX_CLOCK     = 8'h00;
  // field positions
  localparam int unsigned POS_SECURITY = 7;
  localparam int unsigned POS_PM_LOCK  = 6;
  localparam int unsigned POS_RS_LOCK  = 5;
  localparam int unsigned POS_WDR      = 3;
  localparam int unsigned POS_BOD_OFF  = 2;

  typedef enum logic [2:0] {
    HCB_CLK_RSVD0 = 3'b000,
    HCB_CLK_RSVD1 = 3'b001,
    HCB_CLK_RSVD2 = 3'b010,
    HCB_CLK_EXT   = 3'b011,
    HCB_CLK_PLLHF = 3'b100,
    HCB_CLK_PLLLF = 3'b101,
    HCB_CLK_OSCHF = 3'b110,
    HCB_CLK_OSCLF = 3'b111
  } hcb_clk_code_t;

  typedef enum logic [2:0] {
    HCB_DF_NONE = 3'b000,
    HCB_DF_1K   = 3'b001,
    HCB_DF_2K   = 3'b010,
    HCB_DF_4K   = 3'b100
  } hcb_df_size_t;

  // special-function bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hcb_sfr_req_t;

  // serial programmer write request
  typedef struct packed {
    logic       wr;
    logic       mass_erase;
    logic [5:0] index;
    logic [7:0] data;
  } hcb_prog_req_t;

  // decoded system options
  typedef struct packed {
    logic watchdog_reset_en;
    logic brownout_detect_on;
    logic clk_external;
    logic clk_pll_hf;
    logic clk_pll_lf;
    logic clk_osc_hf;
    logic clk_osc_lf;
    logic clk_invalid;
    logic [2:0] data_flash_size;
    logic pm_write_ok;
    logic rs_write_ok;
  } hcb_opts_t;
endpackage

// File: hw/hcb_config_bytes.sv
// hardware configuration byte store, indirect read port and option decode
`timescale 1ns/1ps
`default_nettype none

// How it works
// - watchdog reset enabled when bit 3 set
// - two-bit field selects data flash size
// - brownout detect on when bit 2 clear
// - clock codes 011,100,101: external, pll hf/lf
// - clock codes 110,111: oscillator hf/lf
// - bytes change only via serial programming path
// - software reads bytes through index/value pair
// - index register 93, value register 94
// - byte writes accepted only in program mode
// - security bit blocks writes until mass erase
// - program memory lock beats reset sector lock
module hcb_config_bytes
(
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_prog_mode,
  input  wire logic                  i_large_mem,
  input  wire hcb_pkg::hcb_sfr_req_t  i_sfr,
  input  wire hcb_pkg::hcb_prog_req_t i_prog,
  output logic [7:0]                 o_sfr_rdata,
  output logic                       o_sfr_hit,
  output logic                       o_prog_done,
  output logic                       o_prog_refused,
  output hcb_pkg::hcb_opts_t          o_opts
);
  import hcb_pkg::*;

  // nonvolatile array, models flash cells
  logic [7:0]               mem_q [NUM_CFG_BYTES];
  logic [NUM_CFG_BYTES-1:0] cell_wr;
  logic [5:0]               index_q;
  logic [5:0]               index_d;
  logic [7:0]               rdata_q;
  logic [7:0]               rdata_d;
  logic                     hit_q;
  logic                     hit_d;
  logic                     done_q;
  logic                     done_d;
  logic                     refused_q;
  logic                     refused_d;
  logic [7:0]               sel_byte;
  hcb_opts_t                opts_q;
  hcb_opts_t                opts_d;
  hcb_clk_code_t            clk_code;
  hcb_df_size_t             df_size;

  // read views with the fixed bits forced
  wire logic [7:0] sys_byte = (mem_q[IDX_SYSTEM] & MASK_SYSTEM) | FIX_SYSTEM;
  wire logic [7:0] bod_byte = (mem_q[IDX_BROWNOUT] & MASK_BROWNOUT) | FIX_BROWNOUT;
  wire logic [7:0] clk_byte = (mem_q[IDX_CLOCK] & MASK_CLOCK) | FIX_CLOCK;

  // security bit active low: 0 locks
  wire logic secured  = ~sys_byte[POS_SECURITY];
  wire logic prog_any = i_prog.wr | i_prog.mass_erase;
  wire logic wr_ok    = i_prog.wr & i_prog_mode & ~secured;
  wire logic erase_ok = i_prog.mass_erase & i_prog_mode;
  wire logic refused  = prog_any & ~(wr_ok | erase_ok);

  // software writes only reach the index register, never the bytes
  wire logic idx_sel = (i_sfr.addr == SFR_CFG_INDEX);
  wire logic val_sel = (i_sfr.addr == SFR_CFG_VALUE);
  wire logic idx_wr  = i_sfr.wr & idx_sel;
  wire logic idx_rd  = i_sfr.rd & idx_sel;
  wire logic val_rd  = i_sfr.rd & val_sel;

  // byte picked by the index register
  always_comb
  begin
    if (index_q == IDX_SYSTEM)
      sel_byte = sys_byte;
    else if (index_q == IDX_BROWNOUT)
      sel_byte = bod_byte;
    else if (index_q == IDX_CLOCK)
      sel_byte = clk_byte;
    else
      sel_byte = mem_q[index_q];
  end

  // read data: value register, index register, else zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (val_rd)
      rdata_d = sel_byte;
    else if (idx_rd)
      rdata_d = {2'b00, index_q};
  end

  // clock source decode, reserved codes select no mode
  assign clk_code = hcb_clk_code_t'(clk_byte[2:0]);
  wire logic mode_ext    = (clk_code == HCB_CLK_EXT);
  wire logic mode_pll_hf = (clk_code == HCB_CLK_PLLHF);
  wire logic mode_pll_lf = (clk_code == HCB_CLK_PLLLF);
  wire logic mode_osc_hf = (clk_code == HCB_CLK_OSCHF);
  wire logic mode_osc_lf = (clk_code == HCB_CLK_OSCLF);
  wire logic mode_rsvd   = ~(mode_ext | mode_pll_hf | mode_pll_lf | mode_osc_hf | mode_osc_lf);

  // data flash size, 4k only on the larger variant
  always_comb
  begin
    case (sys_byte[1:0])
      2'b00:   df_size = i_large_mem ? HCB_DF_4K : HCB_DF_NONE;
      2'b01:   df_size = HCB_DF_2K;
      2'b10:   df_size = HCB_DF_1K;
      default: df_size = HCB_DF_NONE;
    endcase
  end

  // program memory lock overrides the reset sector lock
  wire logic pm_open = ~sys_byte[POS_PM_LOCK];
  wire logic rs_open = ~sys_byte[POS_RS_LOCK] & pm_open;

  // decoded options
  always_comb
  begin
    opts_d                    = '0;
    opts_d.watchdog_reset_en  = sys_byte[POS_WDR];
    opts_d.brownout_detect_on = ~bod_byte[POS_BOD_OFF];
    opts_d.clk_external       = mode_ext;
    opts_d.clk_pll_hf         = mode_pll_hf;
    opts_d.clk_pll_lf         = mode_pll_lf;
    opts_d.clk_osc_hf         = mode_osc_hf;
    opts_d.clk_osc_lf         = mode_osc_lf;
    opts_d.clk_invalid        = mode_rsvd;
    opts_d.data_flash_size    = df_size;
    opts_d.pm_write_ok        = pm_open;
    opts_d.rs_write_ok        = rs_open;
  end

  // next values of the registers
  assign index_d   = idx_wr ? i_sfr.wdata[5:0] : index_q;
  assign hit_d     = idx_wr | idx_rd | val_rd;
  assign done_d    = wr_ok | erase_ok;
  assign refused_d = refused;

  // one write strobe per cell
  for (genvar g = 0; g < NUM_CFG_BYTES; g++)
  begin : g_cell_wr
    assign cell_wr[g] = wr_ok & (i_prog.index == 6'(g));
  end

  // cells are nonvolatile: reset leaves them, only programming changes them
  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < NUM_CFG_BYTES; i++)
    begin
      if (erase_ok)
        mem_q[i] <= RST_OTHER;
      else if (cell_wr[i])
        mem_q[i] <= i_prog.data;
    end
  end

  // registers below are cleared by the synchronous reset

  // indirect index register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      index_q <= 6'h00;
    else
      index_q <= index_d;
  end

  // read data register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // address hit pulse
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      hit_q <= 1'b0;
    else
      hit_q <= hit_d;
  end

  // programming accepted pulse
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      done_q <= 1'b0;
    else
      done_q <= done_d;
  end

  // programming ignored pulse
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      refused_q <= 1'b0;
    else
      refused_q <= refused_d;
  end

  // registered option decode
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      opts_q <= '0;
    else
      opts_q <= opts_d;
  end

  // outputs straight from flip-flops
  assign o_sfr_rdata    = rdata_q;
  assign o_sfr_hit      = hit_q;
  assign o_prog_done    = done_q;
  assign o_prog_refused = refused_q;
  assign o_opts         = opts_q;
endmodule

`default_nettype wire

// File: test/hcb_config_bytes_monitor.sv
// checker for the configuration byte block
`timescale 1ns/1ps
`default_nettype none
module hcb_config_bytes_monitor
(
  input wire logic                   i_clk,
  input wire logic                   i_srst,
  input wire logic                   i_prog_mode,
  input wire logic                   i_large_mem,
  input wire hcb_pkg::hcb_sfr_req_t  i_sfr,
  input wire hcb_pkg::hcb_prog_req_t i_prog,
  input wire logic [7:0]             o_sfr_rdata,
  input wire logic                   o_sfr_hit,
  input wire logic                   o_prog_done,
  input wire logic                   o_prog_refused,
  input wire hcb_pkg::hcb_opts_t     o_opts
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire sel = (i_sfr.rd && (i_sfr.addr == 8'h93 || i_sfr.addr == 8'h94)) || (i_sfr.wr && i_sfr.addr == 8'h93);
  property p_hit; sel |=> o_sfr_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_nohit; !sel |=> !o_sfr_hit; endproperty
  a_nohit: assert property (p_nohit) else $error("nohit");
  property p_nord; !i_sfr.rd |=> o_sfr_rdata == 8'h00; endproperty
  a_nord: assert property (p_nord) else $error("rdata");
  property p_ref; i_prog.wr && !i_prog.mass_erase && !i_prog_mode |=> o_prog_refused; endproperty
  a_ref: assert property (p_ref) else $error("refuse");
  property p_ok; o_prog_done |-> $past(i_prog_mode); endproperty
  a_ok: assert property (p_ok) else $error("done");
  property p_ers; i_prog.mass_erase && i_prog_mode |=> o_prog_done; endproperty
  a_ers: assert property (p_ers) else $error("erase");
  property p_osc; o_opts.clk_osc_lf |-> !o_opts.clk_osc_hf; endproperty
  a_osc: assert property (p_osc) else $error("clock");
  property p_lock; o_opts.rs_write_ok |-> o_opts.pm_write_ok; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  c_ers: cover property (o_prog_done);
  c_ref: cover property (o_prog_refused);
  c_ext: cover property (o_opts.clk_external);
endmodule
bind hcb_config_bytes hcb_config_bytes_monitor u_mon (.*);
`default_nettype wire

// File: test/hcb_prog_host.sv
// serial programming host model
`timescale 1ns/1ps
`default_nettype none
module hcb_prog_host
(
  input wire logic                  i_clk,
  output var hcb_pkg::hcb_prog_req_t o_req
);
  initial o_req = '0;
  task automatic send(input logic er, input logic [5:0] ix, input logic [7:0] d);
    if (ix == 6'h3d && d[2:0] < 3'h3) d[2:0] = 3'h3;
    @(negedge i_clk) o_req = {~er, er, ix, d};
    @(negedge i_clk) o_req = {2'h0, ~ix, ~d};
  endtask
endmodule
`default_nettype wire

// File: test/hcb_config_bytes_tb.sv
// bench for the configuration byte block
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch %0t got %h want %h", $time, a, b); end end
module hcb_config_bytes_tb;
  import hcb_pkg::*;
  logic          clk, rst, pm, lm, hit, done, refd;
  logic [7:0]    rdat, s, b, c, m [64];
  hcb_sfr_req_t  sfr;
  hcb_prog_req_t prg;
  hcb_opts_t     opt;
  int            n_mismatch, compares, cyc;
  hcb_config_bytes u_dut (.i_clk(clk), .i_srst(rst), .i_prog_mode(pm), .i_large_mem(lm), .i_sfr(sfr),
    .i_prog(prg), .o_sfr_rdata(rdat), .o_sfr_hit(hit), .o_prog_done(done), .o_prog_refused(refd), .o_opts(opt));
  hcb_prog_host u_host (.i_clk(clk), .o_req(prg));
  initial begin clk = 0; forever #10 clk = ~clk; end
  always @(posedge clk) if (++cyc > 900) begin n_mismatch++; conclude(); end
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] rv(input logic [5:0] i);
    return i == 6'h3f ? m[i] & 8'hfb | 8'h04 : i == 6'h3e ? m[i] & 8'h04 | 8'hfb : i == 6'h3d ? m[i] & 8'h07 : m[i];
  endfunction
  function automatic hcb_opts_t ex(input logic [7:0] s, b, c);
    return {s[3], ~b[2], c[2:0] == 3'h3, c[2:0] == 3'h4, c[2:0] == 3'h5, c[2:0] == 3'h6, c[2:0] == 3'h7,
      1'b0, s[1:0] == 2'h3 ? 3'h0 : s[1:0] == 2'h2 ? 3'h1 : s[1:0] == 2'h1 ? 3'h2 : {lm, 2'h0}, ~s[6], ~s[5] & ~s[6]};
  endfunction
  task automatic rd(input logic [5:0] i);
    @(negedge clk) sfr = {1'b1, 1'b0, 8'h93, 2'h0, i};
    @(negedge clk) sfr = {1'b0, 1'b1, 8'h94, 8'h00};
    @(negedge clk) sfr = '0;
    `CK(rdat, rv(i))
    `CK(hit, 1'b1)
  endtask
  task automatic wr(input logic er, input logic [5:0] i, input logic [7:0] d, input logic ok);
    u_host.send(er, i, d);
    `CK(done, ok)
    `CK(refd, !ok)
    if (ok && er) foreach (m[k]) m[k] = 8'hff;
    else if (ok) m[i] = d;
  endtask
  initial begin
    void'($urandom(32'h852cf2f8));
    rst = 1; pm = 1; lm = 0; sfr = '0;
    repeat (6) @(negedge clk);
    rst = 0;
    wr(1'b1, 6'h00, 8'h00, 1'b1);
    for (int k = 0; k < 10; k++) begin
      s = 8'($urandom) | 8'h80; b = 8'($urandom); c = 8'($urandom); lm = 1'($urandom);
      c[2:0] = 3'h3 + 3'(k % 5);
      if (k == 0) begin s = 8'hff; b = 8'hff; c = 8'hff; end
      if (k == 1 || k == 2) begin s[1:0] = 2'h0; lm = k[0]; end
      wr(1'b0, 6'h3d, c, 1'b1); wr(1'b0, 6'h3e, b, 1'b1); wr(1'b0, 6'h3f, s, 1'b1);
      repeat (2) @(negedge clk);
      `CK(opt, ex(s, b, c))
      rd(6'h3f); rd(6'h3e); rd(6'h3d);
    end
    pm = 0;
    wr(1'b0, 6'h3f, 8'h00, 1'b0);
    @(negedge clk) sfr = {1'b1, 1'b0, 8'h94, 8'h00};
    @(negedge clk) sfr = {1'b0, 1'b1, 8'h90, 8'h00};
    @(negedge clk) sfr = '0;
    `CK(rdat, 8'h00)
    `CK(hit, 1'b0)
    rd(6'h3f);
    rd(6'h3d);
    pm = 1;
    wr(1'b0, 6'h3f, 8'h7f, 1'b1);
    wr(1'b0, 6'h3d, 8'h06, 1'b0);
    wr(1'b1, 6'h00, 8'h00, 1'b1);
    rd(6'h3d);
    conclude();
  end
endmodule
`default_nettype wire
